// ### hw/asfde_fifo.sv
// Purpose: Word FIFO with registered read data and flush
// Assumes: Caller never relies on writes when full or reads when empty
// Notes: Count is exact; full and empty come from it
`timescale 1ns/10ps
module asfde_fifo #(
    parameter int DW = 32,
    parameter int DEPTH = 64
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic flush_in,
    input wire logic wr_in,
    input wire logic [DW-1:0] wr_data_in,
    input wire logic rd_in,
    output logic [DW-1:0] rd_data_out,
    output logic [$clog2(DEPTH):0] count_out,
    output logic full_out,
    output logic empty_out
);
    localparam int PW = $clog2(DEPTH);

    logic [DW-1:0] mem_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0] cnt_q;
    logic [DW-1:0] rd_q;
    wire do_wr = wr_in && !full_out;
    wire do_rd = rd_in && !empty_out;

    assign full_out = (cnt_q == PW'(0) + (PW+1)'(DEPTH));
    assign empty_out = (cnt_q == '0);
    assign count_out = cnt_q;
    assign rd_data_out = rd_q;

    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem_q[wp_q] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            rd_q <= '0;
        end else if (flush_in) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wp_q <= wp_q + PW'(1);
            end
            if (do_rd) begin
                rp_q <= rp_q + PW'(1);
                rd_q <= mem_q[rp_q];
            end
            cnt_q <= cnt_q + (PW+1)'(do_wr) - (PW+1)'(do_rd);
        end
    end
endmodule

// ### hw/asfde_pkg.sv
// Purpose: Shared constants and types of the audio serial FIFO and DMA event block
// Assumes: 32-bit register port, one core clock
// Notes: Thresholds sit in bits 15:8 of each FIFO control register
package asfde_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] ASFDE_RXCTL_OFS = 8'h00;
    localparam logic [7:0] ASFDE_TXCTL_OFS = 8'h04;
    localparam logic [7:0] ASFDE_STAT_OFS = 8'h08;
    localparam logic [7:0] ASFDE_MASK_OFS = 8'h0C;
    localparam logic [7:0] ASFDE_LEVEL_OFS = 8'h10;
    // ==========================================
    // Fields and reset values
    localparam int ASFDE_EN_BIT = 0;
    localparam int ASFDE_FLUSH_BIT = 1;
    localparam int ASFDE_THR_LSB = 8;
    localparam int ASFDE_THR_MSB = 15;
    localparam int ASFDE_TXLVL_LSB = 16;
    localparam logic [8:0] ASFDE_CTL_RST = 9'h000;
    localparam logic [3:0] ASFDE_STAT_RST = 4'h0;
    localparam logic [3:0] ASFDE_MASK_RST = 4'h0;
    localparam int ASFDE_DEPTH = 64;
    localparam int ASFDE_DATA_W = 32;
    localparam logic [7:0] ASFDE_PEND_MAX = 8'hFF;

    // ==========================================
    // Types
    typedef struct packed {
        logic [7:0] thr;
        logic en;
    } asfde_cfg_t;

    typedef struct packed {
        logic tx_evt;
        logic rx_evt;
        logic tx_unf;
        logic rx_ovf;
    } asfde_stat_t;

    // Word counter step: wraps to zero and flags when threshold is reached
    function automatic logic [8:0] asfde_step(input logic [7:0] cnt, input logic [7:0] thr, input logic hit);
        if (!hit || thr == 8'h00) begin
            return {1'b0, cnt};
        end
        if (cnt + 8'h01 >= thr) begin
            return {1'b1, 8'h00};
        end
        return {1'b0, cnt + 8'h01};
    endfunction

    // Pending event count: a set and a clear together cancel
    function automatic logic [7:0] asfde_pend(input logic [7:0] p, input logic set, input logic clr);
        case ({set, clr})
            2'b10: return (p == ASFDE_PEND_MAX) ? p : p + 8'h01;
            2'b01: return (p == 8'h00) ? p : p - 8'h01;
            default: return p;
        endcase
    endfunction
endpackage

// ### hw/asfde_top.sv
// Purpose: Receive and transmit FIFOs of a serial audio port with DMA level events
// Assumes: Serializer strobes and DMA strobes come from logic on core_clk_in
// Notes: Pending events are counted, so a set and clear together never drop an event
`timescale 1ns/10ps
module asfde_top
    import asfde_pkg::*;
#(
    parameter int DW = ASFDE_DATA_W,
    parameter int DEPTH = ASFDE_DEPTH
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic pin_rx_valid_in,
    input wire logic [DW-1:0] pin_rx_data_in,
    input wire logic pin_tx_req_in,
    output logic [DW-1:0] pin_tx_data_out,
    input wire logic dma_rx_rd_in,
    output logic [DW-1:0] dma_rx_data_out,
    input wire logic dma_tx_wr_in,
    input wire logic [DW-1:0] dma_tx_data_in,
    output logic rx_event_out,
    output logic tx_event_out,
    output logic irq_out
);
    localparam int CW = $clog2(DEPTH) + 1;

    // ==========================================
    // Register decode
    wire wr_rxctl = reg_wr_in && (reg_addr_in == ASFDE_RXCTL_OFS);
    wire wr_txctl = reg_wr_in && (reg_addr_in == ASFDE_TXCTL_OFS);
    wire wr_mask = reg_wr_in && (reg_addr_in == ASFDE_MASK_OFS);
    wire rd_stat = reg_rd_in && (reg_addr_in == ASFDE_STAT_OFS);
    wire rx_flush = wr_rxctl && reg_wdata_in[ASFDE_FLUSH_BIT];
    wire tx_flush = wr_txctl && reg_wdata_in[ASFDE_FLUSH_BIT];

    asfde_cfg_t rx_cfg_q;
    asfde_cfg_t tx_cfg_q;
    asfde_stat_t stat_q;
    asfde_stat_t stat_d;
    asfde_stat_t mask_q;
    asfde_stat_t mask_d;
    asfde_cfg_t wcfg;

    assign wcfg.thr = reg_wdata_in[ASFDE_THR_MSB:ASFDE_THR_LSB];
    assign wcfg.en = reg_wdata_in[ASFDE_EN_BIT];
    assign mask_d = wr_mask ? asfde_stat_t'(reg_wdata_in[3:0]) : mask_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_cfg_q <= asfde_cfg_t'(ASFDE_CTL_RST);
            tx_cfg_q <= asfde_cfg_t'(ASFDE_CTL_RST);
            mask_q <= asfde_stat_t'(ASFDE_MASK_RST);
        end else begin
            if (wr_rxctl) begin
                rx_cfg_q <= wcfg;
            end
            if (wr_txctl) begin
                tx_cfg_q <= wcfg;
            end
            mask_q <= mask_d;
        end
    end

    // ==========================================
    // FIFO storage
    logic [CW-1:0] rx_cnt;
    logic [CW-1:0] tx_cnt;
    logic rx_full;
    logic rx_empty;
    logic tx_full;
    logic tx_empty;

    wire rx_pin_try = pin_rx_valid_in && rx_cfg_q.en;
    wire tx_pin_try = pin_tx_req_in && tx_cfg_q.en;
    wire rx_pin_hit = rx_pin_try && !rx_full;
    wire tx_pin_hit = tx_pin_try && !tx_empty;
    wire rx_dma_hit = dma_rx_rd_in && !rx_empty;
    wire tx_dma_hit = dma_tx_wr_in && !tx_full;
    wire rx_ovf = rx_pin_try && rx_full;
    wire tx_unf = tx_pin_try && tx_empty;

    // Receive path: pins fill, DMA drains
    asfde_fifo #(
        .DW(DW),
        .DEPTH(DEPTH)
    ) u_rx_fifo (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(rx_flush),
        .wr_in(rx_pin_hit),
        .wr_data_in(pin_rx_data_in),
        .rd_in(dma_rx_rd_in),
        .rd_data_out(dma_rx_data_out),
        .count_out(rx_cnt),
        .full_out(rx_full),
        .empty_out(rx_empty)
    );

    // Transmit path: DMA fills, pins drain
    asfde_fifo #(
        .DW(DW),
        .DEPTH(DEPTH)
    ) u_tx_fifo (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(tx_flush),
        .wr_in(tx_dma_hit),
        .wr_data_in(dma_tx_data_in),
        .rd_in(tx_pin_hit),
        .rd_data_out(pin_tx_data_out),
        .count_out(tx_cnt),
        .full_out(tx_full),
        .empty_out(tx_empty)
    );

    // ==========================================
    // Threshold word counters
    logic [7:0] rx_set_cnt_q;
    logic [7:0] rx_clr_cnt_q;
    logic [7:0] tx_set_cnt_q;
    logic [7:0] tx_clr_cnt_q;
    logic [8:0] rx_set_st;
    logic [8:0] rx_clr_st;
    logic [8:0] tx_set_st;
    logic [8:0] tx_clr_st;

    assign rx_set_st = asfde_step(rx_set_cnt_q, rx_cfg_q.thr, rx_pin_hit);
    assign rx_clr_st = asfde_step(rx_clr_cnt_q, rx_cfg_q.thr, rx_dma_hit);
    assign tx_set_st = asfde_step(tx_set_cnt_q, tx_cfg_q.thr, tx_pin_hit);
    assign tx_clr_st = asfde_step(tx_clr_cnt_q, tx_cfg_q.thr, tx_dma_hit);

    wire rx_set = rx_set_st[8];
    wire rx_clr = rx_clr_st[8];
    // Transmit enable rising asks DMA for the first block, unless the same write sets the flush bit
    wire tx_start = wr_txctl && wcfg.en && !tx_cfg_q.en;
    wire tx_set = tx_set_st[8] || tx_start;
    wire tx_clr = tx_clr_st[8];

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_set_cnt_q <= 8'h00;
            rx_clr_cnt_q <= 8'h00;
            tx_set_cnt_q <= 8'h00;
            tx_clr_cnt_q <= 8'h00;
        end else begin
            rx_set_cnt_q <= rx_flush ? 8'h00 : rx_set_st[7:0];
            rx_clr_cnt_q <= rx_flush ? 8'h00 : rx_clr_st[7:0];
            tx_set_cnt_q <= tx_flush ? 8'h00 : tx_set_st[7:0];
            tx_clr_cnt_q <= tx_flush ? 8'h00 : tx_clr_st[7:0];
        end
    end

    // ==========================================
    // Pending events towards the DMA controller
    logic [7:0] rx_pend_q;
    logic [7:0] tx_pend_q;
    logic [7:0] rx_pend_d;
    logic [7:0] tx_pend_d;

    assign rx_pend_d = rx_flush ? 8'h00 : asfde_pend(rx_pend_q, rx_set, rx_clr);
    assign tx_pend_d = tx_flush ? 8'h00 : asfde_pend(tx_pend_q, tx_set, tx_clr);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_pend_q <= 8'h00;
            tx_pend_q <= 8'h00;
            rx_event_out <= 1'b0;
            tx_event_out <= 1'b0;
        end else begin
            rx_pend_q <= rx_pend_d;
            tx_pend_q <= tx_pend_d;
            rx_event_out <= (rx_pend_d != 8'h00);
            tx_event_out <= (tx_pend_d != 8'h00);
        end
    end

    // ==========================================
    // Sticky status, mask and interrupt
    asfde_stat_t stat_set;

    assign stat_set.rx_ovf = rx_ovf;
    assign stat_set.tx_unf = tx_unf;
    assign stat_set.rx_evt = rx_set;
    assign stat_set.tx_evt = tx_set;
    // Hardware set wins over the read clear
    assign stat_d = (rd_stat ? asfde_stat_t'(4'h0) : stat_q) | stat_set;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stat_q <= asfde_stat_t'(ASFDE_STAT_RST);
            irq_out <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_out <= |(stat_d & mask_d);
        end
    end

    // ==========================================
    // Read data, one cycle after the strobe
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (reg_addr_in)
            ASFDE_RXCTL_OFS: rdata_d = {16'h0000, rx_cfg_q.thr, 7'h00, rx_cfg_q.en};
            ASFDE_TXCTL_OFS: rdata_d = {16'h0000, tx_cfg_q.thr, 7'h00, tx_cfg_q.en};
            ASFDE_STAT_OFS: rdata_d = {28'h0000000, stat_q};
            ASFDE_MASK_OFS: rdata_d = {28'h0000000, mask_q};
            ASFDE_LEVEL_OFS: rdata_d = {(16-CW)'(0), tx_cnt, (16-CW)'(0), rx_cnt};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_d;
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

    // ==========================================
    // Checks
    sequence s_rx_both;
        rx_set && rx_clr && (rx_pend_q == 8'h01);
    endsequence

    sequence s_tx_both;
        tx_set && tx_clr && (tx_pend_q == 8'h01);
    endsequence

    property p_rx_hold;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $fell(rx_event_out) |-> $past(rx_clr || rx_flush);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx event fell without a clear");

    property p_tx_hold;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $fell(tx_event_out) |-> $past(tx_clr || tx_flush);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx event fell without a clear");

    property p_rx_clear;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        rx_clr && !rx_set && rx_pend_q == 8'h01 |=> !rx_event_out;
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("rx event not cleared");

    property p_rx_set;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        rx_pin_hit && rx_cfg_q.thr == 8'h01 && !rx_flush |=> rx_event_out;
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("rx event not set");

    property p_thr;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        wr_rxctl |=> rx_cfg_q.thr == $past(reg_wdata_in[15:8]);
    endproperty
    a_thr: assert property (p_thr) else $error("rx threshold not taken");

    property p_conflict;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (s_rx_both and !rx_flush) |=> rx_event_out [*2];
    endproperty
    a_conflict: assert property (p_conflict) else $error("rx event lost in conflict");

    property p_tx_conflict;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (s_tx_both and !tx_flush) |=> tx_event_out;
    endproperty
    a_tx_conflict: assert property (p_tx_conflict) else $error("tx event lost in conflict");

    property p_ovf;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        rx_ovf |=> stat_q.rx_ovf ##1 (stat_q.rx_ovf || $past(rd_stat));
    endproperty
    a_ovf: assert property (p_ovf) else $error("rx overflow not flagged");

    property p_unf;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        tx_unf |=> stat_q.tx_unf;
    endproperty
    a_unf: assert property (p_unf) else $error("tx underflow not flagged");

    property p_depth;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        rx_full |-> rx_cnt == CW'(DEPTH) && !$past(rx_cnt > CW'(DEPTH));
    endproperty
    a_depth: assert property (p_depth) else $error("rx depth wrong");

    property p_irq;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        |(stat_q & mask_q) && !rd_stat && !wr_mask |=> irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule

// ### verification/asfde_dma_model.sv
// Purpose: Behavioural DMA controller serving the FIFO level events
// Assumes: Events are registered levels on the core clock
// Notes: After each burst it lets the event update land before looking again
`timescale 1ns/10ps
module asfde_dma_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic go_in,
    input wire logic [3:0] gap_in,
    input wire logic [7:0] rx_thr_in,
    input wire logic [7:0] tx_thr_in,
    input wire logic rx_event_in,
    input wire logic tx_event_in,
    output logic dma_rx_rd_out,
    output logic dma_tx_wr_out,
    output logic [31:0] dma_tx_data_out
);
    logic [31:0] seq_q;
    // ==========================================
    // Receive service
    initial begin
        dma_rx_rd_out = 1'b0;
        forever begin
            @(posedge clk_in);
            if (go_in && rst_n_in && rx_event_in === 1'b1) begin
                repeat (gap_in) @(posedge clk_in);
                repeat (rx_thr_in) begin
                    dma_rx_rd_out <= 1'b1;
                    @(posedge clk_in);
                end
                dma_rx_rd_out <= 1'b0;
                @(posedge clk_in);
            end
        end
    end
    // ==========================================
    // Transmit service, released data lines invert
    initial begin
        dma_tx_wr_out = 1'b0;
        dma_tx_data_out = 32'h00000000;
        seq_q = 32'h00000000;
        forever begin
            @(posedge clk_in);
            if (go_in && rst_n_in && tx_event_in === 1'b1) begin
                repeat (gap_in) @(posedge clk_in);
                repeat (tx_thr_in) begin
                    dma_tx_wr_out <= 1'b1;
                    dma_tx_data_out <= seq_q;
                    seq_q = seq_q + 32'h00000001;
                    @(posedge clk_in);
                end
                dma_tx_wr_out <= 1'b0;
                dma_tx_data_out <= ~dma_tx_data_out;
                @(posedge clk_in);
            end
        end
    end
endmodule

// ### verification/testbench.sv
// Purpose: Self-checking bench of the audio FIFO and DMA event block
// Assumes: Register map and timing as handed over by the designer
// Notes: Receive data is checked by a monitor against pushed words
`timescale 1ns/10ps
module testbench;
    import asfde_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pin_rx_valid = 1'b0, pin_tx_req = 1'b0;
    logic tb_rx_rd = 1'b0, go = 1'b0, rd_q = 1'b0, txq = 1'b0, tx_mon = 1'b1;
    logic [7:0] reg_addr = 8'h00, rx_thr = 8'h00, tx_thr = 8'h00;
    logic [3:0] gap = 4'h0;
    logic [31:0] reg_wdata = 32'h00000000, pin_rx_data = 32'h00000000, rdata, rd_v, word = 32'hA0000000;
    logic [31:0] tx_exp = 32'h00000000, m_tx_data, pin_tx_data, dma_rx_data;
    logic m_rx_rd, m_tx_wr, rx_event, tx_event, irq;
    logic [31:0] rxq[$];
    int fails = 0, checks = 0, cyc = 0;
    wire dma_rx_rd = m_rx_rd | tb_rx_rd;
    asfde_top dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .pin_rx_valid_in(pin_rx_valid),
        .pin_rx_data_in(pin_rx_data), .pin_tx_req_in(pin_tx_req), .pin_tx_data_out(pin_tx_data),
        .dma_rx_rd_in(dma_rx_rd), .dma_rx_data_out(dma_rx_data), .dma_tx_wr_in(m_tx_wr),
        .dma_tx_data_in(m_tx_data), .rx_event_out(rx_event), .tx_event_out(tx_event), .irq_out(irq));
    asfde_dma_model dma_u (.clk_in(clk), .rst_n_in(rst_n), .go_in(go), .gap_in(gap), .rx_thr_in(rx_thr),
        .tx_thr_in(tx_thr), .rx_event_in(rx_event), .tx_event_in(tx_event), .dma_rx_rd_out(m_rx_rd),
        .dma_tx_wr_out(m_tx_wr), .dma_tx_data_out(m_tx_data));
    // ==========================================
    // Clock, timeout and monitors
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            results();
        end
        if (rd_q) begin
            cmp("dma_rx_data", rxq.pop_front(), dma_rx_data);
        end
        if (txq) begin
            cmp("pin_tx_data", tx_exp, pin_tx_data);
            tx_exp = tx_exp + 32'h00000001;
        end
        rd_q <= dma_rx_rd;
        txq <= pin_tx_req & tx_mon;
    end
    // ==========================================
    // Shared tasks
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic push_rx(input int n);
        for (int i = 0; i < n; i++) begin
            pin_rx_valid <= 1'b1;
            pin_rx_data <= word;
            rxq.push_back(word);
            word = word + 32'h00000001;
            @(posedge clk);
        end
        pin_rx_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic drain_tx(input int n);
        pin_tx_req <= 1'b1;
        wait_cyc(n);
        pin_tx_req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
        reg_read(a, rd_v);
        cmp(name, exp, rd_v);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        cmp("events_irq", 32'h0, {29'h0, rx_event, tx_event, irq});
        chk_reg("rxctl", ASFDE_RXCTL_OFS, 32'h0);
        chk_reg("txctl", ASFDE_TXCTL_OFS, 32'h0);
        chk_reg("stat", ASFDE_STAT_OFS, 32'h0);
        chk_reg("mask", ASFDE_MASK_OFS, 32'h0);
        chk_reg("level", ASFDE_LEVEL_OFS, 32'h0);
        chk_reg("unmapped", 8'h14, 32'h0);
    endtask
    task automatic t_rx_basic();
        rx_thr = 8'h04;
        go = 1'b1;
        reg_write(ASFDE_RXCTL_OFS, 32'h00000401);
        chk_reg("rxctl", ASFDE_RXCTL_OFS, 32'h00000401);
        push_rx(3);
        wait_cyc(1);
        cmp("rx_event", 32'h0, {31'h0, rx_event});
        push_rx(1);
        wait_cyc(1);
        cmp("rx_event", 32'h1, {31'h0, rx_event});
        wait_cyc(12);
        cmp("rx_event", 32'h0, {31'h0, rx_event});
        chk_reg("level", ASFDE_LEVEL_OFS, 32'h0);
        chk_reg("stat", ASFDE_STAT_OFS, 32'h4);
        go = 1'b0;
    endtask
    task automatic t_conflict();
        rx_thr = 8'h02;
        reg_write(ASFDE_RXCTL_OFS, 32'h00000203);
        push_rx(2);
        for (int off = 0; off < 3; off++) begin
            for (int c = 0; c < off + 2; c++) begin
                pin_rx_valid <= (c < 2);
                pin_rx_data <= word;
                if (c < 2) begin
                    rxq.push_back(word);
                    word = word + 32'h00000001;
                end
                tb_rx_rd <= (c >= off);
                @(posedge clk);
            end
            pin_rx_valid <= 1'b0;
            tb_rx_rd <= 1'b0;
            wait_cyc(3);
            cmp("rx_event", 32'h1, {31'h0, rx_event});
            chk_reg("level", ASFDE_LEVEL_OFS, 32'h2);
        end
        tb_rx_rd <= 1'b1;
        wait_cyc(2);
        tb_rx_rd <= 1'b0;
        wait_cyc(2);
        cmp("rx_event", 32'h0, {31'h0, rx_event});
        reg_write(ASFDE_RXCTL_OFS, 32'h00000103);
        push_rx(1);
        cmp("rx_event", 32'h1, {31'h0, rx_event});
        tb_rx_rd <= 1'b1;
        @(posedge clk);
        tb_rx_rd <= 1'b0;
        wait_cyc(1);
        cmp("rx_event", 32'h0, {31'h0, rx_event});
    endtask
    task automatic t_overflow();
        reg_write(ASFDE_RXCTL_OFS, 32'h00002003);
        reg_write(ASFDE_MASK_OFS, 32'h1);
        push_rx(ASFDE_DEPTH);
        chk_reg("level", ASFDE_LEVEL_OFS, 32'h40);
        cmp("irq", 32'h0, {31'h0, irq});
        push_rx(1);
        void'(rxq.pop_back());
        wait_cyc(1);
        cmp("irq", 32'h1, {31'h0, irq});
        chk_reg("stat", ASFDE_STAT_OFS, 32'h5);
        wait_cyc(1);
        cmp("irq", 32'h0, {31'h0, irq});
        reg_write(ASFDE_RXCTL_OFS, 32'h00002003);
        rxq.delete();
        wait_cyc(1);
        cmp("rx_event", 32'h0, {31'h0, rx_event});
        chk_reg("level", ASFDE_LEVEL_OFS, 32'h0);
    endtask
    task automatic t_tx();
        tx_thr = 8'h04;
        gap = 4'h5;
        go = 1'b1;
        reg_write(ASFDE_MASK_OFS, 32'h2);
        reg_write(ASFDE_TXCTL_OFS, 32'h00000401);
        wait_cyc(20);
        cmp("tx_event", 32'h0, {31'h0, tx_event});
        chk_reg("level", ASFDE_LEVEL_OFS, 32'h00040000);
        drain_tx(4);
        wait_cyc(1);
        cmp("tx_event", 32'h1, {31'h0, tx_event});
        wait_cyc(20);
        chk_reg("level", ASFDE_LEVEL_OFS, 32'h00040000);
        go = 1'b0;
        drain_tx(4);
        tx_mon = 1'b0;
        drain_tx(1);
        wait_cyc(1);
        cmp("pin_tx_data", 32'h7, pin_tx_data);
        cmp("irq", 32'h1, {31'h0, irq});
        chk_reg("stat", ASFDE_STAT_OFS, 32'hA);
        cmp("tx_event", 32'h1, {31'h0, tx_event});
    endtask
    task automatic results();
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        wait_cyc(8);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_rx_basic();
        t_conflict();
        t_overflow();
        t_tx();
        results();
    end
endmodule
